// ---- hdl/hw_limit_timer.sv ----
/*
  8-bit hardware limit timer with mode controlled start, reset and stop,
  registers over AXI4-Lite.
  assumes external_reset_signal is asynchronous to clk; the timer counts
  on rising clk edges while running.
*/
`timescale 1ns/1ns
`include "hw_limit_timer_defs.svh"
module hw_limit_timer
  import hw_limit_timer_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`TMR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`TMR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   external_reset_signal,
  output logic [7:0]                  count_value,
  output logic                        timer_running
);

  function automatic op_t mode_op(input logic [4:0] m);
    case (m[4:3])
      2'h0: mode_op = OP_PERIOD;
      2'h1: mode_op = OP_ONESHOT;
      2'h2: mode_op = (m[2:0] == 3'h0 || m[2:1] == 2'h2) ? OP_RESERVED : OP_MONO;
      default: mode_op = OP_RESERVED;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  ctrl_t                   ctrl;
  logic [7:0]              period_register;
  logic [7:0]              counter_register;
  logic                    started;
  logic                    aw_have;
  logic                    w_have;
  logic [`TMR_ADDR_W-1:0]  wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic                    wr_fire;
  logic                    ers_s1;
  logic                    ers_s2;
  logic                    ers_s3;
  logic                    ers_lvl;
  logic                    ers_prev;

  // ------------------------------------------------------------------
  // external signal synchroniser and edges
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ers_s1   <= 1'b0;
      ers_s2   <= 1'b0;
      ers_s3   <= 1'b0;
      ers_lvl  <= 1'b0;
      ers_prev <= 1'b0;
    end else begin
      ers_s1   <= external_reset_signal;
      ers_s2   <= ers_s1;
      ers_s3   <= ers_s2;
      // a change counts once two samples agree
      if (ers_s2 == ers_s3) begin
        ers_lvl <= ers_s3;
      end
      ers_prev <= ers_lvl;
    end
  end

  logic rise;
  logic fall;
  logic any_edge;
  assign rise     = ers_lvl & ~ers_prev;
  assign fall     = ~ers_lvl & ers_prev;
  assign any_edge = rise | fall;

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  op_t        op;
  logic [2:0] code;
  logic       gate;
  logic       edge_rst;
  logic       hold_rst;
  logic       start;
  logic       running;
  logic       match;
  logic       clears_en;

  assign op   = mode_op(ctrl.mode);
  assign code = ctrl.mode[2:0];

  always_comb begin
    gate     = 1'b1;
    edge_rst = 1'b0;
    hold_rst = 1'b0;
    start    = 1'b0;
    case (op)
      OP_PERIOD: begin
        case (code)
          3'h1: gate = ers_lvl;
          3'h2: gate = ~ers_lvl;
          3'h3: edge_rst = any_edge;
          3'h4: edge_rst = rise;
          3'h5: edge_rst = fall;
          3'h6: hold_rst = ~ers_lvl;
          3'h7: hold_rst = ers_lvl;
          default: gate = 1'b1;
        endcase
      end
      OP_ONESHOT: begin
        case (code)
          3'h0: start = 1'b1;
          3'h1: start = rise;
          3'h2: start = fall;
          3'h3: start = any_edge;
          3'h4: begin
            start    = rise;
            edge_rst = rise & started;
          end
          3'h5: begin
            start    = fall;
            edge_rst = fall & started;
          end
          3'h6: begin
            start    = rise;
            hold_rst = ~ers_lvl;
          end
          default: begin
            start    = fall;
            hold_rst = ers_lvl;
          end
        endcase
      end
      OP_MONO: begin
        case (code)
          3'h1: start = rise;
          3'h2: start = fall;
          3'h3: start = any_edge;
          3'h6: begin
            start    = ers_lvl;
            hold_rst = ~ers_lvl;
          end
          3'h7: begin
            start    = ~ers_lvl;
            hold_rst = ers_lvl;
          end
          default: hold_rst = 1'b1;
        endcase
      end
      default: hold_rst = 1'b1;
    endcase
  end

  assign running   = ((op == OP_PERIOD) ? (ctrl.en & gate) : (ctrl.en & started)) & ~hold_rst;
  assign match     = (counter_register == period_register);
  // level-started selections end like one-shots
  assign clears_en = (op == OP_ONESHOT) || (op == OP_MONO && code[2:1] == 2'h3);

  // ------------------------------------------------------------------
  // counter and start state
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_register <= 8'h00;
    end else if (hold_rst || edge_rst) begin
      counter_register <= 8'h00;
    end else if (running) begin
      // a match ends the period, or the one-shot at zero
      counter_register <= match ? 8'h00 : counter_register + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      started <= 1'b0;
    end else if (!ctrl.en || hold_rst || op == OP_PERIOD) begin
      started <= 1'b0;
    end else if (started && match && !edge_rst) begin
      started <= 1'b0;
    end else if (start) begin
      started <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have & ~s_axi_bvalid;
  assign wr_fire       = aw_have & w_have & ~s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TMR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_addr == `TMR_CTRL_ADDR || wr_addr == `TMR_PERIOD_ADDR
                       || wr_addr == `TMR_COUNT_ADDR || wr_addr == `TMR_STATUS_ADDR)
                      ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic ctrl_wr_lo;
  assign ctrl_wr_lo = wr_fire && wr_addr == `TMR_CTRL_ADDR && wr_strb[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else begin
      if (ctrl_wr_lo) begin
        ctrl.en <= wr_data[`TMR_EN_BIT];
      end else if (running && match && clears_en && !edge_rst && !hold_rst) begin
        ctrl.en <= 1'b0;
      end
      if (wr_fire && wr_addr == `TMR_CTRL_ADDR && wr_strb[1]) begin
        ctrl.mode <= wr_data[`TMR_MODE_LSB +: `TMR_MODE_W];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period_register <= `TMR_PERIOD_RST;
    end else if (wr_fire && wr_addr == `TMR_PERIOD_ADDR && wr_strb[0]) begin
      period_register <= wr_data[7:0];
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TMR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `TMR_RESP_OKAY;
      case (s_axi_araddr)
        `TMR_CTRL_ADDR:   s_axi_rdata <= {19'h0, ctrl.mode, 7'h0, ctrl.en};
        `TMR_PERIOD_ADDR: s_axi_rdata <= {24'h0, period_register};
        `TMR_COUNT_ADDR:  s_axi_rdata <= {24'h0, counter_register};
        `TMR_STATUS_ADDR: s_axi_rdata <= {28'h0, op == OP_RESERVED, started, ers_lvl,
                                          running};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TMR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_value   <= 8'h00;
      timer_running <= 1'b0;
    end else begin
      count_value   <= counter_register;
      timer_running <= running;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_GATE_LOW_STOPS: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h01 && ctrl.en && !ers_lvl) |=> $stable(counter_register))
    else $error("gated counter moved while gate low");

  AST_RISE_RESETS: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h04 && ctrl.en && rise) |=> counter_register == 8'h00)
    else $error("rising edge did not reset period count");

  AST_LOW_HOLDS: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h06 && !ers_lvl) |=> counter_register == 8'h00)
    else $error("low level did not hold count reset");

  AST_EDGE_STARTS: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h09 && ctrl.en && rise && !started && !ctrl_wr_lo) |=> started)
    else $error("rising edge did not start one-shot");

  AST_RESTART_EDGE: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h0C && started && ctrl.en && rise) |=> counter_register == 8'h00)
    else $error("later rising edge did not reset one-shot");

  AST_OS_LOW_RESET: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h0E && !ers_lvl) |=> (counter_register == 8'h00 && !started))
    else $error("low level did not hold one-shot reset");

  AST_OS_HIGH_RESET: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h0F && ers_lvl) |=> counter_register == 8'h00)
    else $error("high level did not hold one-shot reset");

  AST_OS_END: assert property (@(posedge clk) disable iff (rst)
    (op == OP_ONESHOT && running && match && !hold_rst && !edge_rst && !ctrl_wr_lo)
    |=> (!ctrl.en && counter_register == 8'h00 ##1 counter_register == 8'h00))
    else $error("one-shot did not end at zero with enable cleared");

  AST_MONO_START: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h12 && ctrl.en && fall && !started && !ctrl_wr_lo) |=> started)
    else $error("falling edge did not start monostable");

  AST_MONO_END: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h11 && running && match && !ctrl_wr_lo)
    |=> (ctrl.en && !started && counter_register == 8'h00))
    else $error("monostable end wrong");

  AST_LEVEL_START: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h16 && ctrl.en && ers_lvl && !started && !ctrl_wr_lo) |=> started)
    else $error("high level did not start level one-shot");

  AST_INV_LEVEL: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h17 && ers_lvl) |=> (counter_register == 8'h00 && !started))
    else $error("high level did not hold inverse level one-shot");

  AST_FRESH_EDGE: assert property (@(posedge clk) disable iff (rst)
    (ctrl.mode == 5'h09 && !started && !rise) |=> !started)
    else $error("one-shot started without an edge");

  AST_RESERVED_IDLE: assert property (@(posedge clk) disable iff (rst)
    (op == OP_RESERVED) |=> (counter_register == 8'h00 && !timer_running))
    else $error("reserved mode counted");

endmodule

// ---- include/hw_limit_timer_defs.svh ----
/*
  register map, field positions and reset values of the limit timer.
  assumes a 32-bit AXI4-Lite master with 5-bit byte addresses.
*/
`ifndef HW_LIMIT_TIMER_DEFS_SVH
`define HW_LIMIT_TIMER_DEFS_SVH
`define TMR_ADDR_W     5
`define TMR_CTRL_ADDR  5'h00
`define TMR_PERIOD_ADDR 5'h04
`define TMR_COUNT_ADDR 5'h08
`define TMR_STATUS_ADDR 5'h0C
`define TMR_EN_BIT     0
`define TMR_MODE_LSB   8
`define TMR_MODE_W     5
`define TMR_PERIOD_RST 8'hFF
`define TMR_RESP_OKAY  2'h0
`define TMR_RESP_SLVERR 2'h2
`endif

// ---- include/hw_limit_timer_pkg.sv ----
/*
  types shared by the limit timer.
  assumes hw_limit_timer_defs.svh for the numbers.
*/
package hw_limit_timer_pkg;
  typedef enum logic [1:0] {OP_PERIOD, OP_ONESHOT, OP_MONO, OP_RESERVED} op_t;
  typedef struct packed {
    logic [4:0] mode;
    logic       en;
  } ctrl_t;
endpackage

// ---- verif/ext_trigger_src.sv ----
/*
  partner model: on-chip source of the external reset/trigger signal.
  assumes the bench sets level_req and lag just after a clk edge.
*/
`timescale 1ns/1ns
module ext_trigger_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       level_req,
  input  wire logic [2:0] lag,
  output logic            external_reset_signal
);
  logic [7:0] pipe;

  // lag 0 answers at once, larger lags model a slow source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pipe <= 8'h00;
    end else begin
      pipe <= {pipe[6:0], level_req};
    end
  end

  assign external_reset_signal = (lag == 3'h0) ? level_req : pipe[lag - 3'h1];
endmodule

// ---- verif/tb_top.sv ----
/*
  self-checking bench of the limit timer: mode table, start edges, ends,
  edge resets, level holds and re-enable.
  assumes ext_trigger_src drives the external signal.
*/
`timescale 1ns/1ns
`include "hw_limit_timer_defs.svh"
module tb_top;
  logic                   clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                   s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic                   s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_running;
  logic                   external_reset_signal, trig_lvl, saw;
  logic [`TMR_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]            s_axi_wdata, s_axi_rdata, c;
  logic [3:0]             s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic [7:0]             count_value;
  logic [2:0]             lag;
  logic [4:0]             md;
  logic [6:0]             rows [20] = '{7'h01, 7'h04, 7'h07, 7'h0A, 7'h09, 7'h18, 7'h1B,
    7'h1E, 7'h1D, 7'h21, 7'h24, 7'h38, 7'h5B, 7'h58, 7'h5D, 7'h5E, 7'h62, 7'h40, 7'h50, 7'h56};
  logic [4:0]             em [5] = '{5'h03, 5'h04, 5'h05, 5'h0C, 5'h0D};
  int                     err_total, check_count;

  hw_limit_timer dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_reset_signal,
    .count_value, .timer_running);
  ext_trigger_src src (.clk, .rst, .level_req(trig_lvl), .lag, .external_reset_signal);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim;
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk(s_axi_bresp, r);
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic ctrl(input logic [4:0] m, input logic e);
    wr(`TMR_CTRL_ADDR, (32'(m) << `TMR_MODE_LSB) | 32'(e), `TMR_RESP_OKAY);
  endtask

  // moves the pin and notes whether the counter ran meanwhile
  task automatic set_sig(input logic v);
    trig_lvl <= v;
    saw = 1'b0;
    repeat (16) begin
      @(posedge clk);
      saw |= timer_running;
    end
  endtask

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #400000;
    err_total++;
    end_sim();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, trig_lvl, lag} = '0;
    s_axi_wstrb = 4'hF;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`TMR_CTRL_ADDR, 32'h0, `TMR_RESP_OKAY);
    rd(`TMR_PERIOD_ADDR, 32'hFF, `TMR_RESP_OKAY);
    rd(5'h10, 32'h0, `TMR_RESP_SLVERR);
    wr(5'h14, 32'h1, `TMR_RESP_SLVERR);
    wr(`TMR_COUNT_ADDR, 32'h55, `TMR_RESP_OKAY);
    rd(`TMR_COUNT_ADDR, 32'h0, `TMR_RESP_OKAY);
    foreach (rows[i]) begin
      ctrl(5'h00, 1'b0);
      set_sig(rows[i][1]);
      ctrl(rows[i][6:2], 1'b1);
      repeat (10) @(posedge clk);
      chk(timer_running, rows[i][0]);
    end
    rd(`TMR_STATUS_ADDR, 32'hA, `TMR_RESP_OKAY);
    wr(`TMR_PERIOD_ADDR, 32'h05, `TMR_RESP_OKAY);
    ctrl(5'h08, 1'b1);
    repeat (20) @(posedge clk);
    chk(count_value, 32'h0);
    rd(`TMR_CTRL_ADDR, 32'h800, `TMR_RESP_OKAY);
    for (int b = 1; b < 3; b++) begin
      for (int m = 1; m < 4; m++) begin
        md = 5'(b * 8 + m);
        ctrl(5'h00, 1'b0);
        set_sig(m == 2);
        ctrl(md, 1'b1);
        set_sig(m != 2);
        chk(saw, 1);
        chk(count_value, 32'h0);
        rd(`TMR_CTRL_ADDR, (32'(md) << 8) | 32'(b == 2), `TMR_RESP_OKAY);
        set_sig(m == 2);
        chk(saw, (b == 2 && m == 3));
      end
    end
    wr(`TMR_PERIOD_ADDR, 32'hFF, `TMR_RESP_OKAY);
    foreach (em[i]) begin
      ctrl(5'h00, 1'b0);
      set_sig(em[i][2] & em[i][0]);
      ctrl(em[i], 1'b1);
      set_sig(!(em[i][2] & em[i][0]));
      repeat (40) @(posedge clk);
      chk(count_value > 8'h20, 1);
      set_sig(em[i][2] & em[i][0]);
      chk(count_value < 8'h14, em[i] == 5'h03);
      set_sig(!(em[i][2] & em[i][0]));
      chk(count_value < 8'h14, 1);
      chk(timer_running, 1);
      ctrl(em[i], 1'b0);
      repeat (4) @(posedge clk);
      c = 32'(count_value);
      repeat (8) @(posedge clk);
      chk(count_value, c);
      rd(`TMR_COUNT_ADDR, c, `TMR_RESP_OKAY);
    end
    for (int k = 0; k < 2; k++) begin
      ctrl(5'h00, 1'b0);
      set_sig(k[0]);
      ctrl(5'(5'h0E + k), 1'b1);
      set_sig(!k);
      chk(saw, 1);
      set_sig(k[0]);
      chk(count_value, 32'h0);
    end
    ctrl(5'h00, 1'b0);
    set_sig(1'b0);
    ctrl(5'h09, 1'b1);
    set_sig(1'b1);
    chk(saw, 1);
    ctrl(5'h09, 1'b0);
    ctrl(5'h09, 1'b1);
    repeat (10) @(posedge clk);
    chk(timer_running, 0);
    lag <= 3'h5;
    set_sig(1'b0);
    set_sig(1'b1);
    chk(saw, 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(count_value, 32'h0);
    chk(timer_running, 0);
    rst <= 1'b0;
    rd(`TMR_CTRL_ADDR, 32'h0, `TMR_RESP_OKAY);
    rd(`TMR_PERIOD_ADDR, 32'hFF, `TMR_RESP_OKAY);
    end_sim();
  end
endmodule
